//--- vfp_config_regs.sv
// Purpose: Fast processor configuration register bank with apply logic
// Assumes: Host port on sys_clk_i; meas_* inputs come from same clock
// Notes:   Init sequence is a fixed count stand-in for the processor setup
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "vfp_map.svh"

module vfp_config_regs
  import vfp_pkg::*;
#(
  parameter int INIT_CYCLES = 16
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [`VFP_ADDR_W-1:0]    addr_i,
  input  wire logic [`VFP_DATA_W-1:0]    wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [`VFP_DATA_W-1:0]    rdata_o,
  input  wire logic [`VFP_DATA_W-1:0]    meas_cr_i,
  input  wire logic [`VFP_DATA_W-1:0]    meas_cb_i,
  input  wire logic [`VFP_DATA_W-1:0]    chroma_amp_i,
  output logic      [1:0]                luma_input_sel_o,
  output logic                           chroma_input_sel_o,
  output logic      [1:0]                if_comp_o,
  output logic      [1:0]                chroma_bw_o,
  output logic                           fixed_notch_o,
  output logic                           luma_lowpass_o,
  output logic      [1:0]                hpll_speed_o,
  output logic                           init_busy_o,
  output logic      [11:0]               active_start_o,
  output logic      [5:0]                luma_delay_o,
  output logic      [11:0]               helper_delay_o,
  output logic                           shared_coeff_select_o,
  output logic                           amp_indep_comb_o,
  output logic                           comb_booster_select_o,
  output logic      [1:0]                chroma_comb_strength_o,
  output logic      [1:0]                luma_comb_strength_o,
  output logic      [4:0]                comb_limit_o,
  output logic      [10:0]               db_gain_o,
  output logic      [10:0]               dr_gain_o,
  output logic      [10:0]               helper_gain_o,
  output logic                           color_killed_o
);

  logic [11:0] std_select_reg;
  logic [11:0] input_cfg_reg;
  logic [11:0] act_start_reg;
  logic [11:0] luma_dly_reg;
  logic [11:0] comb_ctrl_reg;
  logic [11:0] helper_dly_reg;
  logic [11:0] color_ref_reg;
  logic [10:0] db_mult_reg;
  logic [10:0] dr_mult_reg;
  logic [10:0] helper_mult_reg;
  logic [11:0] helper_gain_reg;
  logic [11:0] killer_lvl_reg;
  logic [11:0] act_start_live_reg;
  logic [5:0]  luma_dly_live_reg;
  logic [10:0] acc_db_reg;
  logic [10:0] acc_dr_reg;
  logic [10:0] acc_help_reg;
  logic [7:0]  acc_div_reg;
  logic [7:0]  init_cnt_reg;
  logic        init_done_reg;
  vfp_state_t  state_reg;
  logic [11:0] rdata_reg;

  logic wr_std;
  logic wr_incfg;
  logic secam_std;
  logic acc_on;
  logic acc_tick;

  // Exponent 3 bits over mantissa: gain = m * 2^-e, truncated to a word
  function automatic logic [10:0] mant_exp_gain(input logic [10:0] v);
    logic [7:0]  m;
    logic [2:0]  e;
    m = v[7:0];
    e = v[10:8];
    mant_exp_gain = {3'h0, m >> e};
  endfunction : mant_exp_gain

  // Step one multiplier a unit toward the reference
  function automatic logic [10:0] acc_step(input logic [10:0] g,
                                           input logic [11:0] meas,
                                           input logic [11:0] ref_lvl);
    acc_step = g;
    if (meas < ref_lvl && g != 11'h7_ff) begin
      acc_step = g + 11'h0_01;
    end else if (meas > ref_lvl && g != 11'h0_00) begin
      acc_step = g - 11'h0_01;
    end
  endfunction : acc_step

  assign wr_std    = wr_i && (addr_i == `VFP_OFF_STD_SELECT);
  assign wr_incfg  = wr_i && (addr_i == `VFP_OFF_INPUT_CFG);
  assign secam_std = (std_select_reg[2:0] == `VFP_STD_SECAM);
  assign acc_on    = (color_ref_reg != `VFP_RST_ZERO);
  assign acc_tick  = (acc_div_reg == `VFP_ACC_STEP_DIV);

  // Standard select is the trigger for reloads and shadow updates
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      std_select_reg <= `VFP_RST_ZERO;
    end else if (wr_std) begin
      std_select_reg <= wdata_i;
    end
  end

  // Input config; bit 11 is never stored, it reads back the done flag
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_cfg_reg <= `VFP_RST_INPUT_CFG;
    end else if (wr_incfg) begin
      input_cfg_reg <= {1'b0, wdata_i[10:0]};
    end
  end

  // Plain storage registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_start_reg   <= `VFP_RST_ZERO;
      luma_dly_reg    <= `VFP_RST_ZERO;
      comb_ctrl_reg   <= `VFP_RST_COMB_CTRL;
      helper_dly_reg  <= `VFP_RST_ZERO;
      helper_mult_reg <= `VFP_RST_MULT;
      helper_gain_reg <= `VFP_RST_HELPER_GAIN;
      killer_lvl_reg  <= `VFP_RST_KILLER_LVL;
    end else if (wr_i) begin
      if (addr_i == `VFP_OFF_ACT_START) begin
        act_start_reg <= wdata_i;
      end else if (addr_i == `VFP_OFF_LUMA_DLY) begin
        luma_dly_reg <= {6'h0_0, wdata_i[5:0]};
      end else if (addr_i == `VFP_OFF_COMB_CTRL) begin
        comb_ctrl_reg <= wdata_i;
      end else if (addr_i == `VFP_OFF_HELPER_DLY) begin
        helper_dly_reg <= wdata_i;
      end else if (addr_i == `VFP_OFF_HELPER_MULT) begin
        helper_mult_reg <= wdata_i[10:0];
      end else if (addr_i == `VFP_OFF_HELPER_GAIN) begin
        helper_gain_reg <= wdata_i;
      end else if (addr_i == `VFP_OFF_KILLER_LVL) begin
        killer_lvl_reg <= wdata_i;
      end
    end
  end

  // Standard dependent registers: host writes, reload on every standard select write
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      color_ref_reg <= `VFP_RST_REF_PAL;
      db_mult_reg   <= `VFP_RST_MULT;
      dr_mult_reg   <= `VFP_RST_MULT;
    end else if (wr_std) begin
      // A same-cycle host write to these registers loses to the reload
      if (wdata_i[2:0] == `VFP_STD_SECAM) begin
        color_ref_reg <= `VFP_RST_ZERO;
        db_mult_reg   <= `VFP_RST_DB_SECAM;
        dr_mult_reg   <= `VFP_RST_DR_SECAM;
      end else begin
        color_ref_reg <= `VFP_RST_REF_PAL;
        db_mult_reg   <= `VFP_RST_MULT;
        dr_mult_reg   <= `VFP_RST_MULT;
      end
    end else if (wr_i && addr_i == `VFP_OFF_COLOR_REF) begin
      color_ref_reg <= wdata_i;
    end else if (wr_i && addr_i == `VFP_OFF_DB_MULT) begin
      db_mult_reg <= wdata_i[10:0];
    end else if (wr_i && addr_i == `VFP_OFF_DR_MULT) begin
      dr_mult_reg <= wdata_i[10:0];
    end
  end

  // Shadowed position and delay settings
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_start_live_reg <= `VFP_RST_ZERO;
      luma_dly_live_reg  <= 6'h0_0;
    end else if (wr_std) begin
      act_start_live_reg <= act_start_reg;
      // Clamp on apply so a stored value above the limit never goes live
      if (luma_dly_reg[5:0] > `VFP_LDLY_MAX) begin
        luma_dly_live_reg <= `VFP_LDLY_MAX;
      end else begin
        luma_dly_live_reg <= luma_dly_reg[5:0];
      end
    end
  end

  // Initialization sequence started by an input config write
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= VFP_ST_IDLE;
      init_cnt_reg  <= 8'h0_0;
      init_done_reg <= 1'b0;
    end else begin
      case (state_reg)
        VFP_ST_IDLE: begin
          if (wr_incfg) begin
            state_reg     <= VFP_ST_INIT;
            init_cnt_reg  <= 8'(INIT_CYCLES - 1);
            init_done_reg <= 1'b0;
          end
        end
        VFP_ST_INIT: begin
          // A rewrite mid-sequence restarts the count; done stays low
          if (wr_incfg) begin
            init_cnt_reg <= 8'(INIT_CYCLES - 1);
          end else if (init_cnt_reg == 8'h0_0) begin
            state_reg     <= VFP_ST_IDLE;
            init_done_reg <= 1'b1;
          end else begin
            init_cnt_reg <= init_cnt_reg - 8'h0_1;
          end
        end
        default: state_reg <= VFP_ST_IDLE;
      endcase
    end
  end

  // Step divider paces the colour loops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_div_reg <= 8'h0_0;
    end else begin
      acc_div_reg <= acc_tick ? 8'h0_0 : acc_div_reg + 8'h0_1;
    end
  end

  // Automatic colour control loop; one unit per step keeps the gain
  // from hunting on a noisy measurement
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_db_reg   <= `VFP_RST_MULT;
      acc_dr_reg   <= `VFP_RST_MULT;
      acc_help_reg <= `VFP_RST_MULT;
    end else begin
      if (acc_on && acc_tick) begin
        acc_db_reg <= acc_step(acc_db_reg, meas_cb_i, color_ref_reg);
        acc_dr_reg <= acc_step(acc_dr_reg, meas_cr_i, color_ref_reg);
      end
      if (helper_gain_reg != `VFP_RST_ZERO && acc_tick) begin
        acc_help_reg <= acc_step(acc_help_reg, meas_cb_i, helper_gain_reg);
      end
    end
  end

  // Chroma gains: loop values, or manual exponent and mantissa gains
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      db_gain_o <= `VFP_RST_MULT;
      dr_gain_o <= `VFP_RST_MULT;
    end else if (acc_on) begin
      db_gain_o <= acc_db_reg;
      dr_gain_o <= acc_dr_reg;
    end else begin
      db_gain_o <= mant_exp_gain(db_mult_reg);
      dr_gain_o <= mant_exp_gain(dr_mult_reg);
    end
  end

  // Helper gain: a zero gain adjust hands over to the manual multiplier
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      helper_gain_o <= `VFP_RST_MULT;
    end else if (helper_gain_reg == `VFP_RST_ZERO) begin
      helper_gain_o <= mant_exp_gain(helper_mult_reg);
    end else begin
      helper_gain_o <= acc_help_reg;
    end
  end

  // Colour killer; a zero level keeps it off
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      color_killed_o <= 1'b0;
    end else begin
      color_killed_o <= (killer_lvl_reg != `VFP_RST_ZERO) &&
                        (chroma_amp_i < killer_lvl_reg);
    end
  end

  // IF compensation; the per-MHz mode falls back to off outside SECAM
  // so a stale setting cannot distort other standards
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      if_comp_o <= 2'h0;
    end else if (input_cfg_reg[4:3] == `VFP_IF_SECAM_ONLY && !secam_std) begin
      if_comp_o <= 2'h0;
    end else begin
      if_comp_o <= input_cfg_reg[4:3];
    end
  end

  assign luma_input_sel_o       = input_cfg_reg[1:0];
  assign chroma_input_sel_o     = input_cfg_reg[2];
  assign chroma_bw_o            = input_cfg_reg[6:5];
  assign fixed_notch_o          = input_cfg_reg[7];
  assign luma_lowpass_o         = input_cfg_reg[8];
  assign hpll_speed_o           = input_cfg_reg[10:9];
  assign init_busy_o            = (state_reg == VFP_ST_INIT);
  assign active_start_o         = act_start_live_reg;
  assign luma_delay_o           = luma_dly_live_reg;
  assign helper_delay_o         = helper_dly_reg;
  assign shared_coeff_select_o  = comb_ctrl_reg[0];
  assign amp_indep_comb_o       = comb_ctrl_reg[1];
  assign comb_booster_select_o  = comb_ctrl_reg[2];
  assign chroma_comb_strength_o = comb_ctrl_reg[4:3];
  assign luma_comb_strength_o   = comb_ctrl_reg[6:5];
  assign comb_limit_o           = comb_ctrl_reg[11:7];

  // Read decode; unmapped subaddresses read zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= `VFP_RST_ZERO;
    end else if (rd_i) begin
      if (addr_i == `VFP_OFF_STD_SELECT) begin
        rdata_reg <= std_select_reg;
      end else if (addr_i == `VFP_OFF_INPUT_CFG) begin
        // Top bit shows the done flag, never the host's written bit
        rdata_reg <= {init_done_reg, input_cfg_reg[10:0]};
      end else if (addr_i == `VFP_OFF_ACT_START) begin
        rdata_reg <= act_start_reg;
      end else if (addr_i == `VFP_OFF_LUMA_DLY) begin
        rdata_reg <= luma_dly_reg;
      end else if (addr_i == `VFP_OFF_COMB_CTRL) begin
        rdata_reg <= comb_ctrl_reg;
      end else if (addr_i == `VFP_OFF_HELPER_DLY) begin
        rdata_reg <= helper_dly_reg;
      end else if (addr_i == `VFP_OFF_COLOR_REF) begin
        rdata_reg <= color_ref_reg;
      end else if (addr_i == `VFP_OFF_DB_MULT) begin
        rdata_reg <= {1'b0, db_mult_reg};
      end else if (addr_i == `VFP_OFF_DR_MULT) begin
        rdata_reg <= {1'b0, dr_mult_reg};
      end else if (addr_i == `VFP_OFF_HELPER_MULT) begin
        rdata_reg <= {1'b0, helper_mult_reg};
      end else if (addr_i == `VFP_OFF_HELPER_GAIN) begin
        rdata_reg <= helper_gain_reg;
      end else if (addr_i == `VFP_OFF_KILLER_LVL) begin
        rdata_reg <= killer_lvl_reg;
      end else if (addr_i == `VFP_OFF_STATUS) begin
        rdata_reg <= {9'h0_00, color_killed_o, acc_on, init_busy_o};
      end else begin
        rdata_reg <= `VFP_RST_ZERO;
      end
    end
  end

  assign rdata_o = rdata_reg;

endmodule : vfp_config_regs

//--- vfp_map.svh
// Purpose: Register offsets, field positions, reset values for fast proc regs
// Assumes: Subaddresses are 8-bit word indices, data 12 bits wide
// Notes:   Included by the register bank and the host model
`ifndef VFP_MAP_SVH
`define VFP_MAP_SVH

`define VFP_ADDR_W          8
`define VFP_DATA_W          12

`define VFP_OFF_STD_SELECT  8'h20
`define VFP_OFF_INPUT_CFG   8'h21
`define VFP_OFF_ACT_START   8'h22
`define VFP_OFF_LUMA_DLY    8'h23
`define VFP_OFF_COMB_CTRL   8'h27
`define VFP_OFF_HELPER_DLY  8'h29
`define VFP_OFF_COLOR_REF   8'h30
`define VFP_OFF_DB_MULT     8'h32
`define VFP_OFF_DR_MULT     8'h33
`define VFP_OFF_HELPER_MULT 8'h34
`define VFP_OFF_HELPER_GAIN 8'h36
`define VFP_OFF_KILLER_LVL  8'h39
`define VFP_OFF_STATUS      8'h3f

`define VFP_RST_INPUT_CFG   12'h0_024
`define VFP_RST_COMB_CTRL   12'h0_058
`define VFP_RST_ZERO        12'h0_000
`define VFP_RST_HELPER_GAIN 12'h0_313
`define VFP_RST_KILLER_LVL  12'h0_019
`define VFP_RST_REF_PAL     12'h0_816
`define VFP_RST_DB_SECAM    11'h4_83
`define VFP_RST_DR_SECAM    11'h5_d8
`define VFP_RST_MULT        11'h0_00

`define VFP_STD_SECAM       3'h2
`define VFP_IF_SECAM_ONLY   2'h3

`define VFP_INCFG_DONE_BIT  11
`define VFP_LDLY_MAX        6'h1_1

`define VFP_INIT_CYCLES     8'h1_0
`define VFP_ACC_STEP_DIV    8'h4_0

`endif

//--- vfp_pkg.sv
// Purpose: Types for the fast processor configuration register bank
// Assumes: vfp_map.svh holds all numeric constants
// Notes:   Field decodes shared by the bank
package vfp_pkg;
  typedef enum logic [1:0] {
    VFP_LUMA_IN3 = 2'h0,
    VFP_LUMA_IN2 = 2'h1,
    VFP_LUMA_IN1 = 2'h2,
    VFP_LUMA_RSV = 2'h3
  } vfp_luma_sel_t;

  typedef enum logic [1:0] {
    VFP_IFC_OFF  = 2'h0,
    VFP_IFC_6DB  = 2'h1,
    VFP_IFC_12DB = 2'h2,
    VFP_IFC_10DB = 2'h3
  } vfp_ifc_t;

  typedef enum logic [1:0] {
    VFP_HPLL_KEEP  = 2'h0,
    VFP_HPLL_TERR  = 2'h1,
    VFP_HPLL_VCR   = 2'h2,
    VFP_HPLL_MIXED = 2'h3
  } vfp_hpll_t;

  typedef enum logic [1:0] {
    VFP_ST_IDLE = 2'b01,
    VFP_ST_INIT = 2'b10
  } vfp_state_t;
endpackage : vfp_pkg

//--- vfp_host_model.sv
// Purpose: Host side model issuing register writes and reads
// Assumes: One write or read strobe per access, data next cycle
// Notes:   Keeps the host duties on status and reserved bits
`timescale 1ns/1ps
`include "vfp_map.svh"

module vfp_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [11:0] rdata_i,
  output logic      [7:0]  addr_o,
  output logic      [11:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 12'h0_000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [11:0] d);
    logic [11:0] v;
    v = d;
    if (a == `VFP_OFF_INPUT_CFG) v[11] = 1'b0;
    if (a == `VFP_OFF_LUMA_DLY) v[11:6] = 6'h00;
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= v;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [11:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask : rd_reg
endmodule : vfp_host_model

//--- vfp_config_regs_sva.sv
// Purpose: Port checker for the fast processor register bank
// Assumes: Bound to vfp_config_regs
// Notes:   Shadows standard select and killer level from host writes
`timescale 1ns/1ps

module vfp_config_regs_sva #(
  parameter int INIT_CYCLES = 16
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [11:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [11:0] rdata_o,
  input wire logic [11:0] chroma_amp_i,
  input wire logic [10:0] cfg_bits,
  input wire logic [1:0]  if_comp_o,
  input wire logic        init_busy_o,
  input wire logic [11:0] active_start_o,
  input wire logic [5:0]  luma_delay_o,
  input wire logic [11:0] helper_delay_o,
  input wire logic [11:0] comb_bits,
  input wire logic        color_killed_o
);
  logic [2:0]  std_reg;
  logic [11:0] kil_reg;
  int          busy_cnt;
  wire w20 = wr_i && addr_i == 8'h20;
  wire w21 = wr_i && addr_i == 8'h21;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) std_reg <= 3'h0;
    else if (w20) std_reg <= wdata_i[2:0];
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) kil_reg <= 12'h0_019;
    else if (wr_i && addr_i == 8'h39) kil_reg <= wdata_i;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cnt <= 0;
    else if (w21 || !init_busy_o) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  init_start_a: assert property (w21 |=> init_busy_o)
    else $error("init busy not raised after input config write");
  init_length_a: assert property (init_busy_o |-> busy_cnt < INIT_CYCLES)
    else $error("init busy lasts too long");
  done_bit_a: assert property (rd_i && addr_i == 8'h21 && init_busy_o |=>
    !rdata_o[11]) else $error("done bit set during init");
  input_fields_a: assert property (w21 |=>
    cfg_bits == $past({wdata_i[10:5], 2'h0, wdata_i[2:0]}))
    else $error("input config fields mismatch");
  if_secam_a: assert property (if_comp_o == 2'h3 |->
    $past(std_reg) == 3'h2) else $error("10 dB mode outside SECAM");
  shadow_hold_a: assert property (!w20 |=> $stable(active_start_o) &&
    $stable(luma_delay_o)) else $error("shadow changed without std write");
  delay_limit_a: assert property (luma_delay_o <= 6'h11)
    else $error("luma delay above limit");
  helper_delay_a: assert property (wr_i && addr_i == 8'h29 |=>
    helper_delay_o == $past(wdata_i)) else $error("helper delay mismatch");
  comb_fields_a: assert property (wr_i && addr_i == 8'h27 |=>
    comb_bits == $past(wdata_i)) else $error("comb fields mismatch");
  killer_level_a: assert property ($past(rst_n_i) |-> color_killed_o ==
    ($past(kil_reg) != 12'h0_000 && $past(chroma_amp_i) < $past(kil_reg)))
    else $error("color killer state mismatch");
endmodule : vfp_config_regs_sva

bind vfp_config_regs vfp_config_regs_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .chroma_amp_i(chroma_amp_i), .if_comp_o(if_comp_o),
  .cfg_bits({hpll_speed_o, luma_lowpass_o, fixed_notch_o, chroma_bw_o,
    2'h0, chroma_input_sel_o, luma_input_sel_o}),
  .init_busy_o(init_busy_o), .active_start_o(active_start_o),
  .luma_delay_o(luma_delay_o), .helper_delay_o(helper_delay_o),
  .comb_bits({comb_limit_o, luma_comb_strength_o, chroma_comb_strength_o,
    comb_booster_select_o, amp_indep_comb_o, shared_coeff_select_o}),
  .color_killed_o(color_killed_o));

//--- video_decoder_fp_config_regs_tb.sv
// Purpose: Directed test of the fast processor register bank
// Assumes: Short init count of 2 cycles
// Notes:   Host model performs all register accesses
`timescale 1ns/1ps

module video_decoder_fp_config_regs_tb;
  localparam int INIT_N = 2;
  logic sys_clk_i, rst_n_i, wr, rd, cis, notch, lowp, busy, shc, amp, boost;
  logic kill;
  logic [7:0] addr;
  logic [11:0] wdata, rdata, cr, cb, camp, astart, hdly, v, w;
  logic [1:0] vis, ifc, bw, hpll, cstr, ystr;
  logic [5:0] ldel;
  logic [4:0] clim;
  logic [10:0] dbg, drg, hlg;
  int num_errors, check_count, n, m;
  logic [7:0] ra [12] = '{8'h21, 8'h22, 8'h23, 8'h27, 8'h29, 8'h30,
    8'h32, 8'h33, 8'h34, 8'h36, 8'h39, 8'h3c};
  logic [11:0] rv [12] = '{12'h0_024, 12'h0_000, 12'h0_000, 12'h0_058,
    12'h0_000, 12'h0_816, 12'h0_000, 12'h0_000, 12'h0_000, 12'h0_313,
    12'h0_019, 12'h0_000};

  vfp_host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  vfp_config_regs #(.INIT_CYCLES(INIT_N)) u_dut (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .meas_cr_i(cr), .meas_cb_i(cb),
    .chroma_amp_i(camp), .luma_input_sel_o(vis), .chroma_input_sel_o(cis),
    .if_comp_o(ifc), .chroma_bw_o(bw), .fixed_notch_o(notch),
    .luma_lowpass_o(lowp), .hpll_speed_o(hpll), .init_busy_o(busy),
    .active_start_o(astart), .luma_delay_o(ldel), .helper_delay_o(hdly),
    .shared_coeff_select_o(shc), .amp_indep_comb_o(amp),
    .comb_booster_select_o(boost), .chroma_comb_strength_o(cstr),
    .luma_comb_strength_o(ystr), .comb_limit_o(clim), .db_gain_o(dbg),
    .dr_gain_o(drg), .helper_gain_o(hlg), .color_killed_o(kill));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [11:0] e);
    u_host.rd_reg(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rchk

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : idle

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    num_errors = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    cr = 12'h0_100;
    cb = 12'h0_100;
    camp = 12'h0_100;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    idle(1);
    chk("reset outs", 12'h0_0f4,
      {2'h0, kill, bw, cstr, ystr, cis, vis});
    for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
    u_host.wr_reg(8'h20, 12'h0_002);
    u_host.wr_reg(8'h21, 12'hff0);
    #1 n = 1;
    while (busy === 1'b1 && n < 100) begin
      idle(1);
      if (busy === 1'b1) n++;
    end
    if (n >= 100) begin
      num_errors++;
    end
    chk("init length", INIT_N, n);
    rchk(8'h21, 12'hff0);
    rchk(8'h30, 12'h0_000);
    rchk(8'h32, 12'h4_83);
    rchk(8'h33, 12'h5_d8);
    for (m = 0; m < 4; m++) begin
      n = (m == 3);
      w = 12'((m << 9) | (n * 12'h1_84) | (m * 12'h2_9));
      u_host.wr_reg(8'h21, w);
      rchk(8'h21, w);
      idle(1);
      chk("if comp", m, ifc);
      chk("input outs", {m[1:0], n[0], n[0], m[1:0], n[0], m[1:0]},
        {3'h0, hpll, lowp, notch, bw, cis, vis});
    end
    u_host.wr_reg(8'h22, 12'h1_23);
    u_host.wr_reg(8'h23, 12'h0_3f);
    idle(1);
    chk("held start", 12'h0_000, {ldel, astart[5:0]});
    u_host.wr_reg(8'h20, 12'h0_000);
    idle(2);
    chk("active start", 12'h1_23, astart);
    chk("luma delay", 12'h0_11, ldel);
    chk("if comp pal", 12'h0_000, ifc);
    rchk(8'h30, 12'h8_16);
    u_host.wr_reg(8'h27, 12'ha_bc);
    idle(1);
    chk("comb", 12'ha_bc,
      {clim, ystr, cstr, boost, amp, shc});
    u_host.wr_reg(8'h29, 12'hf_ed);
    idle(1);
    chk("helper delay", 12'hf_ed, hdly);
    u_host.wr_reg(8'h30, 12'h0_000);
    u_host.wr_reg(8'h32, 12'h1_40);
    u_host.wr_reg(8'h33, 12'h3_ff);
    u_host.wr_reg(8'h36, 12'h0_000);
    u_host.wr_reg(8'h34, 12'h2_80);
    idle(3);
    chk("db gain", 12'h0_20, dbg);
    chk("dr gain", 12'h0_1f, drg);
    chk("helper gain", 12'h0_20, hlg);
    @(posedge sys_clk_i) camp <= 12'h0_00a;
    idle(2);
    chk("killed", 12'h0_001, kill);
    u_host.wr_reg(8'h39, 12'h0_000);
    idle(2);
    chk("killer off", 12'h0_000, kill);
    u_host.wr_reg(8'h30, 12'h2_00);
    idle(1);
    m = dbg;
    n = drg;
    idle(65);
    chk("acc db", 12'(m + 1), dbg);
    chk("acc dr", 12'(n + 1), drg);
    rchk(8'h3f, 12'h0_002);
    print_verdict();
  end
endmodule : video_decoder_fp_config_regs_tb
